// >>> spimem_pkg.sv
// Shared constants, types and helpers for the serial memory link
`default_nettype none

package spimem_pkg;

  // Array geometry
  localparam int ADDR_W      = 11;          // Byte address width
  localparam int MEM_DEPTH   = 2048;        // Bytes in the array
  localparam int BYTE_W      = 8;           // Bits per transfer unit
  localparam int ADDR_HI_W   = ADDR_W - 8;  // Address bits kept from first byte

  // Command codes
  localparam logic [7:0] OP_SET_WEL = 8'h06;  // Set write enable latch
  localparam logic [7:0] OP_CLR_WEL = 8'h04;  // Clear write enable latch
  localparam logic [7:0] OP_RD_STAT = 8'h05;  // Read status byte
  localparam logic [7:0] OP_WR_STAT = 8'h01;  // Write status byte
  localparam logic [7:0] OP_RD_MEM  = 8'h03;  // Read array
  localparam logic [7:0] OP_WR_MEM  = 8'h02;  // Write array

  // Status byte layout
  localparam int         ST_WEL_BIT  = 1;      // Write enable latch
  localparam int         ST_BP0_BIT  = 2;      // Block protect low
  localparam int         ST_BP1_BIT  = 3;      // Block protect high
  localparam logic [7:0] ST_WR_MASK  = 8'h8C;  // Writable bits
  localparam logic [7:0] ST_RESET    = 8'h00;  // Value after reset

  // Timing
  localparam longint CLK_HZ      = 50000000;  // Core clock rate
  localparam longint SCK_MAX_HZ  = 20000000;  // Fastest link clock
  localparam longint PU_DELAY_US = 250;       // Power-up access delay, us
  localparam int     PU_DELAY_CYC =
    int'((PU_DELAY_US * CLK_HZ + 64'd999999) / 64'd1000000);
  // Half link period, doubled over the minimum for sampling margin
  localparam int     HOST_HALF_CYC =
    2 * int'((CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ));

  // Device framing states
  typedef enum logic [2:0] {
    SPIMEM_D_OPC,
    SPIMEM_D_AHI,
    SPIMEM_D_ALO,
    SPIMEM_D_DATA,
    SPIMEM_D_RDOUT,
    SPIMEM_D_STAT,
    SPIMEM_D_SKIP
  } spimem_dev_e;

  // Host sequencer states
  typedef enum logic [2:0] {
    SPIMEM_H_IDLE,
    SPIMEM_H_LEAD,
    SPIMEM_H_SHIFT,
    SPIMEM_H_TRAIL,
    SPIMEM_H_GAP
  } spimem_host_e;

  // True for the six known command codes
  function automatic logic spimem_op_valid(input logic [7:0] op);
    return (op == OP_SET_WEL) || (op == OP_CLR_WEL) || (op == OP_RD_STAT) ||
           (op == OP_WR_STAT) || (op == OP_RD_MEM) || (op == OP_WR_MEM);
  endfunction : spimem_op_valid

endpackage : spimem_pkg

`default_nettype wire

// >>> spimem_if.sv
// Link wires between the master end and the memory end
`timescale 1ns/1ps
`default_nettype none

interface spimem_if;
  logic cs_n;   // Select, low active
  logic sck;    // Link clock from master
  logic si;     // Master to memory data
  logic so;     // Memory to master data
  logic so_oe;  // Memory drives so
  logic miso;   // Resolved line seen by master

  // Undriven line floats high through a pull-up
  assign miso = so_oe ? so : 1'b1;

  modport dev  (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input miso);
endinterface : spimem_if

`default_nettype wire

// >>> spimem_dev.sv
// Memory end: link shifter, command framing, status byte and byte array
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 11-bit address selects one of 2048 bytes
// - Two address bytes, first five bits dropped
// - Master should send dropped bits as zero
// - Writes land before next transfer starts
// - Master keeps link clock at most 20 MHz
// - Sample input on every rising link edge
// - Output data changes on falling edges
// - Clock level at select picks mode 0/3
// - Mode 3 skips the first falling edge
// - Master idles clock low (0) or high (3)
// - First byte opcode, then address, data
// - One opcode per select, new on fall
// - Deselected: ignore input, output undriven
// - All bytes travel MSB first
// - Bad opcode: ignore rest, output undriven
// - No response during power-up delay
// - Eight-bit status byte configures device
// - Slave only, never starts a transfer
// - Six opcodes valid, all others invalid
// - Drive output only for read data

module spimem_dev
  import spimem_pkg::*;
#(
  parameter int PU_CYC = PU_DELAY_CYC  // Power-up delay in core cycles
)(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  spimem_if.dev           link,
  output logic            dev_ready,
  output logic            cmd_evt,
  output logic [7:0]      cmd_op
);

  // Link-side storage
  logic [7:0]        mem [MEM_DEPTH];   // Byte array
  spimem_dev_e       state_q;           // Framing state
  logic [2:0]        bit_q;             // Bit index within byte
  logic [6:0]        sh_q;              // Received bits so far
  logic              started_q;         // A rising edge seen this frame
  logic [ADDR_W-1:0] addr_q;            // Current byte address
  logic [7:0]        op_q;              // Last accepted opcode
  logic              done_q;            // Command of this frame completed
  logic              cmd_tgl_q;         // Flips per accepted opcode
  logic [7:0]        tx_q;              // Byte being returned
  logic              rd_act_q;          // Read data phase reached
  logic [7:0]        stat_q;            // Stored status bits
  logic              wel_q;             // Write enable latch
  logic              mode3_q;           // Clock was high at select
  logic [2:0]        pu_sync_q;         // Power-up level into link domain
  logic              so_q;              // Output data bit
  logic              oe_q;              // Output enable

  // Core-side storage
  logic [31:0]       pu_cnt_q;          // Power-up counter
  logic              pu_done_q;         // Delay elapsed
  logic [2:0]        tgl_sync_q;        // Opcode toggle synchroniser
  logic              tgl_ack_q;         // Toggle level already reported
  logic              cmd_evt_q;         // Event pulse
  logic [7:0]        cmd_op_q;          // Reported opcode

  // Combinational helpers
  logic              frame_rst;         // Deselect or reset
  logic [7:0]        rx_byte;           // Byte completed at this edge
  logic              byte_end;          // Eighth bit arriving now
  logic              pu_ok;             // Delay seen in link domain
  logic [7:0]        stat_rd;           // Status byte as read
  logic              wr_ok;             // Array write allowed here
  logic [ADDR_W-1:0] addr_nx;           // Next sequential address

  // Deselect clears all per-frame state except op_q and done_q at once
  assign frame_rst = link.cs_n | ~arst_n;
  assign rx_byte   = {sh_q, link.si};
  assign byte_end  = (bit_q == 3'h7);
  assign pu_ok     = pu_sync_q[2] & pu_sync_q[1];
  assign addr_nx   = addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};

  // Status read image: fixed bits zero, latch inserted
  always_comb
  begin
    stat_rd             = stat_q & ST_WR_MASK;
    stat_rd[ST_WEL_BIT] = wel_q;
  end

  // Block protection: none, upper quarter, upper half, all
  always_comb
  begin
    case ({stat_q[ST_BP1_BIT], stat_q[ST_BP0_BIT]})
      2'h0:    wr_ok = wel_q;
      2'h1:    wr_ok = wel_q & (addr_q[10:9] != 2'h3);
      2'h2:    wr_ok = wel_q & ~addr_q[10];
      default: wr_ok = 1'b0;
    endcase
  end

  // Bit counter and input shifter on rising link edges
  always_ff @(posedge link.sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      bit_q     <= 3'h0;
      sh_q      <= 7'h00;
      started_q <= 1'b0;
    end
    else
    begin
      bit_q     <= bit_q + 3'h1;
      sh_q      <= {sh_q[5:0], link.si};
      started_q <= 1'b1;
    end
  end

  // Framing: opcode, address bytes, then data
  always_ff @(posedge link.sck or posedge frame_rst)
  begin
    if (frame_rst)
      state_q <= SPIMEM_D_OPC;
    else if (byte_end)
    begin
      case (state_q)
        // First byte is the opcode
        SPIMEM_D_OPC:
        begin
          if (!pu_ok || !spimem_op_valid(rx_byte))
            state_q <= SPIMEM_D_SKIP;
          else if (rx_byte == OP_RD_MEM || rx_byte == OP_WR_MEM)
            state_q <= SPIMEM_D_AHI;
          else if (rx_byte == OP_RD_STAT)
            state_q <= SPIMEM_D_RDOUT;
          else if (rx_byte == OP_WR_STAT)
            state_q <= SPIMEM_D_STAT;
          else
            state_q <= SPIMEM_D_SKIP;  // Latch commands carry no operand
        end
        SPIMEM_D_AHI:  state_q <= SPIMEM_D_ALO;
        // After the low address byte, the opcode selects read or write data phase
        SPIMEM_D_ALO:
        begin
          if (op_q == OP_RD_MEM)
            state_q <= SPIMEM_D_RDOUT;
          else
            state_q <= SPIMEM_D_DATA;
        end
        SPIMEM_D_STAT: state_q <= SPIMEM_D_SKIP;
        SPIMEM_D_DATA: state_q <= SPIMEM_D_DATA;
        SPIMEM_D_RDOUT: state_q <= SPIMEM_D_RDOUT;
        SPIMEM_D_SKIP: state_q <= SPIMEM_D_SKIP;
        default:       state_q <= SPIMEM_D_SKIP;
      endcase
    end
  end

  // Opcode record and completion flag; survive deselect for the latch
  always_ff @(posedge link.sck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_q      <= 8'h00;
      done_q    <= 1'b0;
      cmd_tgl_q <= 1'b0;
    end
    else if (byte_end)
    begin
      // Opcode accepted only when valid and powered up
      if (state_q == SPIMEM_D_OPC && pu_ok && spimem_op_valid(rx_byte))
      begin
        op_q      <= rx_byte;
        cmd_tgl_q <= ~cmd_tgl_q;
        done_q    <= (rx_byte == OP_SET_WEL) || (rx_byte == OP_CLR_WEL);
      end
      // Status write or array write finished
      else if (state_q == SPIMEM_D_STAT || state_q == SPIMEM_D_DATA)
        done_q <= 1'b1;
    end
    else if (!started_q)
      done_q <= 1'b0;  // New frame forgets the last one
  end

  // Address capture and sequential advance
  always_ff @(posedge link.sck or posedge frame_rst)
  begin
    if (frame_rst)
      addr_q <= '0;
    else if (byte_end)
    begin
      case (state_q)
        // Upper five bits of the first byte dropped
        SPIMEM_D_AHI:   addr_q[ADDR_W-1:8] <= rx_byte[ADDR_HI_W-1:0];
        SPIMEM_D_ALO:   addr_q[7:0] <= rx_byte;
        SPIMEM_D_DATA:  addr_q <= addr_nx;
        SPIMEM_D_RDOUT: addr_q <= addr_nx;
        default:        addr_q <= addr_q;
      endcase
    end
  end

  // Array write completes at the last data bit
  always_ff @(posedge link.sck)
  begin
    if (!link.cs_n && byte_end && state_q == SPIMEM_D_DATA && wr_ok)
      mem[addr_q] <= rx_byte;
  end

  // Return byte and read phase flag
  always_ff @(posedge link.sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      tx_q     <= 8'h00;
      rd_act_q <= 1'b0;
    end
    else if (byte_end)
    begin
      // Status read: repeat status byte
      if ((state_q == SPIMEM_D_OPC && pu_ok && rx_byte == OP_RD_STAT) ||
          (state_q == SPIMEM_D_RDOUT && op_q == OP_RD_STAT))
      begin
        tx_q     <= stat_rd;
        rd_act_q <= 1'b1;
      end
      // Array read: first byte after address
      else if (state_q == SPIMEM_D_ALO && op_q == OP_RD_MEM)
      begin
        tx_q     <= mem[{addr_q[ADDR_W-1:8], rx_byte}];
        rd_act_q <= 1'b1;
      end
      // Array read: following bytes
      else if (state_q == SPIMEM_D_RDOUT)
        tx_q <= mem[addr_nx];
    end
  end

  // Status byte write, guarded by the latch
  always_ff @(posedge link.sck or negedge arst_n)
  begin
    if (!arst_n)
      stat_q <= ST_RESET;
    else if (byte_end && state_q == SPIMEM_D_STAT && wel_q)
      stat_q <= rx_byte & ST_WR_MASK;
  end

  // Write enable latch settles at deselect after a finished command
  always_ff @(posedge link.cs_n or negedge arst_n)
  begin
    if (!arst_n)
      wel_q <= 1'b0;
    else if (done_q)
      wel_q <= (op_q == OP_SET_WEL);
  end

  // Mode from clock level when selected
  always_ff @(negedge link.cs_n or negedge arst_n)
  begin
    if (!arst_n)
      mode3_q <= 1'b0;
    else
      mode3_q <= link.sck;
  end

  // Output on falling edges; first fall in mode 3 skipped
  always_ff @(negedge link.sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (!(mode3_q && !started_q))
    begin
      so_q <= tx_q[~bit_q];
      oe_q <= rd_act_q;
    end
  end

  assign link.so    = so_q;
  assign link.so_oe = oe_q;

  // Power-up level into the link domain
  always_ff @(posedge link.sck or negedge arst_n)
  begin
    if (!arst_n)
      pu_sync_q <= 3'h0;
    else
      pu_sync_q <= {pu_sync_q[1:0], pu_done_q};
  end

  // Power-up delay counter in the core domain
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pu_cnt_q  <= 32'h0;
      pu_done_q <= 1'b0;
    end
    else if (ce && !pu_done_q)
    begin
      pu_cnt_q  <= pu_cnt_q + 32'h1;
      pu_done_q <= (pu_cnt_q >= 32'(PU_CYC - 1));
    end
  end

  // Opcode event into the core domain
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tgl_sync_q <= 3'h0;
      tgl_ack_q  <= 1'b0;
      cmd_evt_q  <= 1'b0;
      cmd_op_q   <= 8'h00;
    end
    else if (ce)
    begin
      tgl_sync_q <= {tgl_sync_q[1:0], cmd_tgl_q};
      cmd_evt_q  <= 1'b0;
      // Pulses cmd_evt when the last two stages agree on a new level
      if (tgl_sync_q[2] == tgl_sync_q[1] && tgl_sync_q[2] != tgl_ack_q)
      begin
        tgl_ack_q <= tgl_sync_q[2];
        cmd_evt_q <= 1'b1;
        cmd_op_q  <= op_q;
      end
    end
  end

  assign dev_ready = pu_done_q;
  assign cmd_evt   = cmd_evt_q;
  assign cmd_op    = cmd_op_q;

endmodule : spimem_dev

`default_nettype wire

// >>> spimem_host.sv
// Master end: frames one command, makes the link clock by division
`timescale 1ns/1ps
`default_nettype none

module spimem_host
  import spimem_pkg::*;
#(
  parameter int PU_CYC = PU_DELAY_CYC  // Wait before first select
)(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  spimem_if.host                 link,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [7:0]        req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [7:0]        req_wdata,
  input  wire logic              req_mode3,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_data
);

  spimem_host_e state_q;     // Sequencer state
  logic [31:0]  pu_cnt_q;    // Power-up wait
  logic         pu_done_q;   // Wait over
  logic [3:0]   cnt_q;       // Cycle within phase
  logic [5:0]   left_q;      // Bits still to send
  logic [31:0]  sh_q;        // Outgoing frame
  logic [7:0]   rx_q;        // Incoming bits
  logic         mode3_q;     // Idle clock level
  logic         rd_q;        // Frame returns data
  logic         cs_n_q;      // Select out
  logic         sck_q;       // Link clock out
  logic         si_q;        // Data out
  logic [2:0]   so_sync_q;   // Returned data synchroniser
  logic         rsp_valid_q; // Answer pulse
  logic [7:0]   rsp_data_q;  // Answer byte

  // Bits per frame for an opcode
  function automatic logic [5:0] frame_bits(input logic [7:0] op);
    if (op == OP_RD_MEM || op == OP_WR_MEM)
      return 6'h20;
    else if (op == OP_RD_STAT || op == OP_WR_STAT)
      return 6'h10;
    else
      return 6'h08;
  endfunction : frame_bits

  assign req_ready = (state_q == SPIMEM_H_IDLE) && pu_done_q && ce;

  // Power-up wait before the first select
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pu_cnt_q  <= 32'h0;
      pu_done_q <= 1'b0;
    end
    else if (ce && !pu_done_q)
    begin
      pu_cnt_q  <= pu_cnt_q + 32'h1;
      pu_done_q <= (pu_cnt_q >= 32'(PU_CYC - 1));
    end
  end

  // Returned data into the core clock
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      so_sync_q <= 3'h0;
    else if (ce)
      so_sync_q <= {so_sync_q[1:0], link.miso};
  end

  // Frame sequencer and link pins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q     <= SPIMEM_H_IDLE;
      cnt_q       <= 4'h0;
      left_q      <= 6'h00;
      sh_q        <= 32'h0;
      rx_q        <= 8'h00;
      mode3_q     <= 1'b0;
      rd_q        <= 1'b0;
      cs_n_q      <= 1'b1;
      sck_q       <= 1'b0;
      si_q        <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end
    else if (ce)
    begin
      rsp_valid_q <= 1'b0;
      cnt_q       <= cnt_q + 4'h1;
      case (state_q)
        // Accept a request, load the frame and set the clock level
        SPIMEM_H_IDLE:
        begin
          cnt_q <= 4'h0;
          sck_q <= mode3_q;
          if (req_valid && req_ready)
          begin
            mode3_q <= req_mode3;
            sck_q   <= req_mode3;
            rd_q    <= (req_op == OP_RD_MEM) || (req_op == OP_RD_STAT);
            left_q  <= frame_bits(req_op);
            if (frame_bits(req_op) == 6'h20)
              sh_q <= {req_op, 5'h00, req_addr, req_wdata};
            else
              sh_q <= {req_op, req_wdata, 16'h0000};
            state_q <= SPIMEM_H_LEAD;
          end
        end
        // Select setup, first bit placed, clock low
        SPIMEM_H_LEAD:
        begin
          // Select a cycle after the idle level settles, so mode is seen cleanly
          if (cnt_q == 4'h0)
            cs_n_q <= 1'b0;
          if (cnt_q == 4'(HOST_HALF_CYC - 1))
          begin
            si_q    <= sh_q[31];
            sck_q   <= 1'b0;
            cnt_q   <= 4'h0;
            state_q <= SPIMEM_H_SHIFT;
          end
        end
        // Low half then high half per bit
        SPIMEM_H_SHIFT:
        begin
          if (cnt_q == 4'(HOST_HALF_CYC - 1))
            sck_q <= 1'b1;
          else if (cnt_q == 4'(2 * HOST_HALF_CYC - 1))
          begin
            rx_q   <= {rx_q[6:0], so_sync_q[2]};
            sh_q   <= {sh_q[30:0], 1'b0};
            left_q <= left_q - 6'h01;
            cnt_q  <= 4'h0;
            // Last bit: data held, clock may stay high in mode 3
            if (left_q == 6'h01)
            begin
              sck_q   <= mode3_q;
              state_q <= SPIMEM_H_TRAIL;
            end
            else
            begin
              si_q  <= sh_q[30];
              sck_q <= 1'b0;
            end
          end
        end
        // Hold, then deselect and answer
        SPIMEM_H_TRAIL:
        begin
          if (cnt_q == 4'(HOST_HALF_CYC - 1))
          begin
            cs_n_q      <= 1'b1;
            rsp_valid_q <= rd_q;
            rsp_data_q  <= rx_q;
            cnt_q       <= 4'h0;
            state_q     <= SPIMEM_H_GAP;
          end
        end
        // Deselect time before the next frame
        SPIMEM_H_GAP:
        begin
          if (cnt_q == 4'(HOST_HALF_CYC - 1))
            state_q <= SPIMEM_H_IDLE;
        end
        default: state_q <= SPIMEM_H_IDLE;
      endcase
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sck  = sck_q;
  assign link.si   = si_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data  = rsp_data_q;

endmodule : spimem_host

`default_nettype wire

// >>> spimem_link_sva.sv
// Checker for the wires between the master end and the memory end
`timescale 1ns/1ps
`default_nettype none

module spimem_link_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic [5:0] rises_q;  // Link rises seen in this frame

  // Count link rises while selected, not the mode idle level itself
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rises_q <= 6'h00;
    else if (cs_n)
      rises_q <= 6'h00;
    else if ($rose(sck) && !$past(cs_n))
      rises_q <= rises_q + 6'h01;
  end

  sequence gap_s;  // Select stays high between frames
    cs_n [*4];
  endsequence
  sequence half_s;  // Link clock holds for a half period
    $stable(sck) [*3];
  endsequence

  deselect_quiet_a: assert property (cs_n |-> !so_oe)
    else $error("so driven while deselected");
  so_fall_a: assert property (!cs_n && $changed(so) |-> !sck)
    else $error("so changed while sck high");
  si_rise_a: assert property (!cs_n && !$past(cs_n) && $changed(si) |-> !sck)
    else $error("si changed while sck high");
  oe_count_a: assert property ($rose(so_oe) |-> rises_q == 6'h08 || rises_q == 6'h18)
    else $error("so driven at wrong bit count");
  oe_hold_a: assert property (so_oe && !cs_n |=> so_oe || cs_n)
    else $error("so released inside a read");
  frame_gap_a: assert property ($rose(cs_n) |-> gap_s)
    else $error("select gap too short");
  sck_rate_a: assert property ($changed(sck) |=> half_s)
    else $error("link clock half period too short");
  sck_idle_a: assert property (cs_n && $past(cs_n) && $changed(sck) |=> !cs_n)
    else $error("link clock moved while deselected");
endmodule : spimem_link_sva

`default_nettype wire

// >>> spi_serial_memory_slave_front_tb.sv
// Testbench joining master end and memory end over the link
`timescale 1ns/1ps
`default_nettype none

module spi_serial_memory_slave_front_tb
  import spimem_pkg::*;
;
  localparam int PU_N     = 8;    // Short power-up delay
  localparam int DEV_PU_N = 100;  // Memory end ready after the first frame

  // One command with its expected read answer
  typedef struct packed {
    logic [7:0]  op;
    logic [10:0] addr;
    logic [7:0]  wd;
    logic        m3;
    logic        chk;
    logic [7:0]  exp;
  } spimem_step_s;

  logic        clk;        // Core clock
  logic        arst_n;     // Reset, low active
  logic        ce;         // Enable both ends
  logic        req_valid;  // Host request
  logic        req_ready;  // Host can take a request
  logic [7:0]  req_op;     // Opcode to send
  logic [10:0] req_addr;   // Byte address
  logic [7:0]  req_wdata;  // Write byte
  logic        req_mode3;  // Clock idles high
  logic        rsp_valid;  // Read answer pulse
  logic [7:0]  rsp_data;   // Read answer
  logic        dev_ready;  // Device power-up done
  logic        cmd_evt;    // Opcode accepted
  logic [7:0]  cmd_op;     // Accepted opcode
  logic [7:0]  rd;         // Last answer
  int          evt_cnt = 0;  // Accepted opcodes
  int          n0;         // Count before a frame
  int          num_errors;
  int          check_count;
  logic [7:0]  ops [6];    // Valid opcodes
  spimem_step_s steps [13];  // Data path sequence

  spimem_if link_if ();
  spimem_dev #(.PU_CYC(DEV_PU_N)) u_spimem_dev (.clk(clk), .arst_n(arst_n), .ce(ce),
    .link(link_if), .dev_ready(dev_ready), .cmd_evt(cmd_evt), .cmd_op(cmd_op));
  spimem_host #(.PU_CYC(PU_N)) u_spimem_host (.clk(clk), .arst_n(arst_n), .ce(ce),
    .link(link_if), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_mode3(req_mode3),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  spimem_link_sva u_spimem_link_sva (.clk(clk), .arst_n(arst_n), .cs_n(link_if.cs_n),
    .sck(link_if.sck), .si(link_if.si), .so(link_if.so), .so_oe(link_if.so_oe));

  // Core clock, 20 ns
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Count accepted opcodes
  always @(posedge clk)
  begin
    if (cmd_evt === 1'b1)
      evt_cnt <= evt_cnt + 1;
  end

  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // One framed command; answer captured at the pulse
  task automatic xfer(input logic [7:0] op, input logic [10:0] addr,
                      input logic [7:0] wd, input logic m3);
    int n;
    n = 0;
    rd = 8'hXX;
    while (req_ready !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 2000)
      begin
        num_errors++;
        report_and_stop();
      end
    end
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= addr;
    req_wdata <= wd;
    req_mode3 <= m3;
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    while (req_ready !== 1'b1)
    begin
      if (rsp_valid === 1'b1)
        rd = rsp_data;
      @(negedge clk);
      n++;
      if (n > 2000)
      begin
        num_errors++;
        report_and_stop();
      end
    end
    check("so_oe idle", link_if.so_oe, 8'h00);
    check("miso idle", link_if.miso, 8'h01);
  endtask : xfer

  // Main sequence
  initial
  begin
    ops = '{OP_SET_WEL, OP_CLR_WEL, OP_RD_STAT, OP_WR_STAT, OP_RD_MEM, OP_WR_MEM};
    steps = '{'{OP_SET_WEL, 11'h000, 8'h00, 1'b0, 1'b0, 8'h00},
              '{OP_WR_MEM, 11'h7FF, 8'hA5, 1'b1, 1'b0, 8'h00},
              '{OP_RD_MEM, 11'h7FF, 8'h00, 1'b0, 1'b1, 8'hA5},
              '{OP_RD_STAT, 11'h000, 8'h00, 1'b1, 1'b1, 8'h00},
              '{OP_WR_MEM, 11'h7FF, 8'h3C, 1'b0, 1'b0, 8'h00},
              '{OP_RD_MEM, 11'h7FF, 8'h00, 1'b1, 1'b1, 8'hA5},
              '{OP_SET_WEL, 11'h000, 8'h00, 1'b0, 1'b0, 8'h00},
              '{OP_WR_MEM, 11'h400, 8'h5A, 1'b1, 1'b0, 8'h00},
              '{OP_RD_MEM, 11'h400, 8'h00, 1'b0, 1'b1, 8'h5A},
              '{OP_RD_MEM, 11'h7FF, 8'h00, 1'b1, 1'b1, 8'hA5},
              '{OP_SET_WEL, 11'h000, 8'h00, 1'b0, 1'b0, 8'h00},
              '{OP_WR_STAT, 11'h000, 8'hFF, 1'b0, 1'b0, 8'h00},
              '{OP_RD_STAT, 11'h000, 8'h00, 1'b0, 1'b1, 8'h8C}};
    arst_n = 1'b0;
    ce = 1'b1;
    req_valid = 1'b0;
    req_op = 8'h00;
    req_addr = 11'h000;
    req_wdata = 8'h00;
    req_mode3 = 1'b0;
    num_errors = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(negedge clk);
    check("dev_ready early", dev_ready, 8'h00);
    check("req_ready early", req_ready, 8'h00);
    // Valid opcode while the memory end is still powering up
    xfer(OP_SET_WEL, 11'h000, 8'h00, 1'b0);
    check("early opcode", 8'(evt_cnt), 8'h00);
    check("dev_ready mid", dev_ready, 8'h00);
    xfer(8'h07, 11'h000, 8'h00, 1'b0);
    check("dev_ready", dev_ready, 8'h01);
    check("invalid first", 8'(evt_cnt), 8'h00);
    $display("test power_up done");
    // Every valid opcode in turn, then an invalid one in mode 3
    for (int i = 0; i < 6; i++)
    begin
      n0 = evt_cnt;
      xfer(ops[i], 11'h000, 8'h00, i[0]);
      check("event count", 8'(evt_cnt - n0), 8'h01);
      check("cmd_op", cmd_op, ops[i]);
    end
    n0 = evt_cnt;
    xfer(8'h83, 11'h000, 8'h00, 1'b1);
    check("invalid event", 8'(evt_cnt - n0), 8'h00);
    $display("test opcodes done");
    // Writes, guarded writes, reads and the status byte
    foreach (steps[i])
    begin
      xfer(steps[i].op, steps[i].addr, steps[i].wd, steps[i].m3);
      if (steps[i].chk)
        check("read data", rd, steps[i].exp);
    end
    $display("test data_path done");
    report_and_stop();
  end
endmodule : spi_serial_memory_slave_front_tb

`default_nettype wire
